// [verilog/dbt_pkg.sv]
`default_nettype none
package dbt_pkg;

	localparam logic [15:0] ADDR_TIMER_CONTROL    = 16'hFE18;
	localparam logic [15:0] ADDR_PRESCALER_CONFIG = 16'hFE19;
	localparam logic [15:0] ADDR_LOW_COUNTER      = 16'hFE1A;
	localparam logic [15:0] ADDR_HIGH_COUNTER     = 16'hFE1B;
	localparam logic [15:0] ADDR_LOW_MATCH_DATA   = 16'hFE1C;
	localparam logic [15:0] ADDR_HIGH_MATCH_DATA  = 16'hFE1D;
	localparam logic [15:0] ADDR_EVENT_CONFIG     = 16'hFE1E;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES   = 8'hFF;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam logic [7:0] ONE_BYTE   = 8'h01;
	localparam logic [8:0] DIV_BASE   = 9'h002;
	localparam logic [8:0] DIV_ONE    = 9'h001;
	localparam int         EVENT_SELECT_BIT = 0;

	typedef enum logic [1:0]
	{
		MODE_TOGGLE_8  = 2'h0,
		MODE_PWM_8     = 2'h1,
		MODE_TOGGLE_16 = 2'h2,
		MODE_PWM_LOW16 = 2'h3
	} dbt_mode_type;

	typedef struct packed
	{
		logic high_run_enable;
		logic low_run_enable;
		logic cascade_select;
		logic output_mode_select;
		logic high_match_flag;
		logic high_irq_enable;
		logic low_match_flag;
		logic low_irq_enable;
	} dbt_control_type;

	typedef struct packed
	{
		logic       enable;
		logic [2:0] ratio;
	} dbt_presc_cfg_type;

	typedef struct packed
	{
		dbt_presc_cfg_type high;
		dbt_presc_cfg_type low;
	} dbt_prescaler_config_type;

	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} dbt_bus_req_type;

	typedef struct packed
	{
		logic [7:0]        count;
		dbt_presc_cfg_type cfg;
	} dbt_presc_state_type;

	typedef struct packed
	{
		logic                     event_sync1;
		logic                     event_sync2;
		logic                     event_prev;
		logic                     half_phase;
		logic                     event_select;
		dbt_control_type          control;
		dbt_prescaler_config_type prescaler_config;
		logic [7:0]               low_match_data;
		logic [7:0]               high_match_data;
		logic [7:0]               low_counter;
		logic [7:0]               high_counter;
		logic [7:0]               low_buffer;
		logic [7:0]               high_buffer;
		logic                     low_output;
		logic                     high_output;
		logic                     irq;
		logic [7:0]               rdata;
	} dbt_state_type;

endpackage
`default_nettype wire

// [verilog/dbt_prescaler.sv]
`default_nettype none
module dbt_prescaler
	import dbt_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              run,
	input  wire logic              tick_in,
	input  wire logic              load,
	input  wire dbt_presc_cfg_type cfg_in,
	output logic                   tick_out
);

	dbt_presc_state_type st;
	dbt_presc_state_type next_st;
	logic [7:0]          limit;

	always_comb
	begin
		next_st = st;
		if (st.cfg.enable)
			limit = 8'((DIV_BASE << st.cfg.ratio) - DIV_ONE);
		else
			limit = ZERO_BYTE;
		tick_out = run && tick_in && (st.count == limit);
		if (!run)
		begin
			// Stopped prescaler is cleared and follows the setting
			next_st.count = ZERO_BYTE;
			next_st.cfg   = cfg_in;
		end
		else
		begin
			if (tick_in)
			begin
				if (tick_out)
					next_st.count = ZERO_BYTE;
				else
					next_st.count = st.count + ONE_BYTE;
			end
			// New ratio takes effect with the match buffer update
			if (load)
				next_st.cfg = cfg_in;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

endmodule
`default_nettype wire

// [verilog/dbt_timer.sv]
// Implementation choice: the address-and-strobe port.
`default_nettype none
module dbt_timer
	import dbt_pkg::*;
(
	input  wire logic            CLK_SYS,
	input  wire logic            SYS_RST,
	input  wire dbt_bus_req_type BUS_REQ,
	output logic [7:0]           BUS_RDATA,
	input  wire logic            EVENT_INPUT_PIN,
	output logic                 LOW_OUTPUT,
	output logic                 HIGH_OUTPUT,
	output logic                 IRQ_REQUEST
);

	dbt_state_type   st;
	dbt_state_type   next_st;
	dbt_mode_type    mode;
	dbt_control_type wctrl;
	logic            half_tick;
	logic            event_edge;
	logic            low_src;
	logic            high_src;
	logic            low_tick;
	logic            high_tick;
	logic            low_match;
	logic            high_match;
	logic            low_overflow;
	logic            high_overflow;
	logic            low_clear_on_match;
	logic            high_clear_on_match;
	logic            high_pwm;
	logic [7:0]      low_next_count;
	logic [7:0]      high_next_count;
	logic            low_zero;
	logic            high_zero;

	assign mode = dbt_mode_type'({st.control.cascade_select, st.control.output_mode_select});

	// Low half prescaler
	dbt_prescaler u_low_presc
	(
		.clk_sys  (CLK_SYS),
		.sys_rst  (SYS_RST),
		.run      (st.control.low_run_enable),
		.tick_in  (low_src),
		.load     (low_zero),
		.cfg_in   (st.prescaler_config.low),
		.tick_out (low_tick)
	);

	// High half prescaler, cleared while high run is off
	dbt_prescaler u_high_presc
	(
		.clk_sys  (CLK_SYS),
		.sys_rst  (SYS_RST),
		.run      (st.control.high_run_enable),
		.tick_in  (high_src),
		.load     (high_zero),
		.cfg_in   (st.prescaler_config.high),
		.tick_out (high_tick)
	);

	// Source selection and counter events
	always_comb
	begin
		half_tick  = st.half_phase;
		event_edge = st.event_sync2 && !st.event_prev;

		case (mode)
			MODE_TOGGLE_8,
			MODE_TOGGLE_16:
				low_src = st.event_select ? event_edge : half_tick;
			MODE_PWM_8,
			MODE_PWM_LOW16:
				low_src = 1'b1;
			default:
				low_src = 1'b0;
		endcase

		low_match    = low_tick && (st.low_counter == st.low_buffer);
		low_overflow = low_tick && (st.low_counter == ALL_ONES);
		low_clear_on_match = !st.control.output_mode_select;

		case (mode)
			MODE_TOGGLE_8:
				high_src = half_tick;
			MODE_PWM_8:
				high_src = 1'b1;
			MODE_TOGGLE_16:
				high_src = low_match;
			MODE_PWM_LOW16:
				high_src = low_overflow;
			default:
				high_src = 1'b0;
		endcase

		high_match    = high_tick && (st.high_counter == st.high_buffer);
		high_overflow = high_tick && (st.high_counter == ALL_ONES);
		high_clear_on_match = (mode != MODE_PWM_8);
		high_pwm = st.control.output_mode_select && !st.control.cascade_select;

		if (low_match && low_clear_on_match)
			low_next_count = ZERO_BYTE;
		else
			low_next_count = st.low_counter + ONE_BYTE;
		if (high_match && high_clear_on_match)
			high_next_count = ZERO_BYTE;
		else
			high_next_count = st.high_counter + ONE_BYTE;

		low_zero  = st.control.low_run_enable && low_tick && (low_next_count == ZERO_BYTE);
		high_zero = st.control.high_run_enable && high_tick && (high_next_count == ZERO_BYTE);
	end

	// Next state
	always_comb
	begin
		next_st = st;
		wctrl   = dbt_control_type'(BUS_REQ.wdata);

		next_st.event_sync1 = EVENT_INPUT_PIN;
		next_st.event_sync2 = st.event_sync1;
		next_st.event_prev  = st.event_sync2;
		next_st.half_phase  = !st.half_phase;

		// Register writes
		if (BUS_REQ.wr)
		begin
			case (BUS_REQ.addr)
				ADDR_TIMER_CONTROL:
				begin
					next_st.control.high_run_enable    = wctrl.high_run_enable;
					next_st.control.low_run_enable     = wctrl.low_run_enable;
					next_st.control.cascade_select     = wctrl.cascade_select;
					next_st.control.output_mode_select = wctrl.output_mode_select;
					next_st.control.high_irq_enable    = wctrl.high_irq_enable;
					next_st.control.low_irq_enable     = wctrl.low_irq_enable;
					next_st.control.high_match_flag    =
						st.control.high_match_flag && wctrl.high_match_flag;
					next_st.control.low_match_flag     =
						st.control.low_match_flag && wctrl.low_match_flag;
				end
				ADDR_PRESCALER_CONFIG:
					next_st.prescaler_config = dbt_prescaler_config_type'(BUS_REQ.wdata);
				ADDR_LOW_MATCH_DATA:
					next_st.low_match_data = BUS_REQ.wdata;
				ADDR_HIGH_MATCH_DATA:
					next_st.high_match_data = BUS_REQ.wdata;
				ADDR_EVENT_CONFIG:
					next_st.event_select = BUS_REQ.wdata[EVENT_SELECT_BIT];
				default:
					next_st.event_select = st.event_select;
			endcase
		end

		// Flags: hardware set wins over software clear
		if (high_zero)
			next_st.control.high_match_flag = 1'b1;
		if (low_zero)
			next_st.control.low_match_flag = 1'b1;

		// Low half counter and buffer
		if (!st.control.low_run_enable)
		begin
			next_st.low_counter = ZERO_BYTE;
			next_st.low_buffer  = st.low_match_data;
		end
		else
		begin
			if (low_tick)
				next_st.low_counter = low_next_count;
			if (low_zero)
				next_st.low_buffer = st.low_match_data;
		end

		// High half counter and buffer
		if (!st.control.high_run_enable)
		begin
			next_st.high_counter = ZERO_BYTE;
			next_st.high_buffer  = st.high_match_data;
		end
		else
		begin
			if (high_tick)
				next_st.high_counter = high_next_count;
			if (high_zero)
				next_st.high_buffer = st.high_match_data;
		end

		// Low output
		if (!st.control.low_run_enable)
			next_st.low_output = 1'b1;
		else if (st.low_match_data == ALL_ONES)
			next_st.low_output = 1'b0;
		else if (!st.control.output_mode_select)
		begin
			if (low_match)
				next_st.low_output = !st.low_output;
		end
		else
		begin
			if (low_match)
				next_st.low_output = 1'b1;
			else if (low_overflow)
				next_st.low_output = 1'b0;
		end

		// High output
		if (!st.control.high_run_enable)
			next_st.high_output = 1'b1;
		else if (st.high_match_data == ALL_ONES)
			next_st.high_output = 1'b0;
		else if (!high_pwm)
		begin
			if (high_match)
				next_st.high_output = !st.high_output;
		end
		else
		begin
			if (high_match)
				next_st.high_output = 1'b1;
			else if (high_overflow)
				next_st.high_output = 1'b0;
		end

		// Shared interrupt request
		next_st.irq =
			(next_st.control.low_irq_enable && next_st.control.low_match_flag) ||
			(next_st.control.high_irq_enable && next_st.control.high_match_flag);

		// Read data, valid the cycle after the strobe
		next_st.rdata = ZERO_BYTE;
		if (BUS_REQ.rd)
		begin
			case (BUS_REQ.addr)
				ADDR_TIMER_CONTROL:
					next_st.rdata = st.control;
				ADDR_PRESCALER_CONFIG:
					next_st.rdata = st.prescaler_config;
				ADDR_LOW_COUNTER:
					next_st.rdata = st.low_counter;
				ADDR_HIGH_COUNTER:
					next_st.rdata = st.high_counter;
				ADDR_LOW_MATCH_DATA:
					next_st.rdata = st.low_match_data;
				ADDR_HIGH_MATCH_DATA:
					next_st.rdata = st.high_match_data;
				ADDR_EVENT_CONFIG:
					next_st.rdata = {7'h00, st.event_select};
				default:
					next_st.rdata = ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			st             <= '0;
			st.low_output  <= 1'b1;
			st.high_output <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign BUS_RDATA   = st.rdata;
	assign LOW_OUTPUT  = st.low_output;
	assign HIGH_OUTPUT = st.high_output;
	assign IRQ_REQUEST = st.irq;

endmodule
`default_nettype wire

// [tb/dbt_timer_sva.sv]
`default_nettype none
module dbt_timer_sva
	import dbt_pkg::*;
(
	input wire logic            CLK_SYS,
	input wire logic            SYS_RST,
	input wire dbt_bus_req_type BUS_REQ,
	input wire logic [7:0]      BUS_RDATA,
	input wire logic            EVENT_INPUT_PIN,
	input wire logic            LOW_OUTPUT,
	input wire logic            HIGH_OUTPUT,
	input wire logic            IRQ_REQUEST
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl;
	logic [7:0] psc;
	logic [7:0] ldat;
	logic [9:0] since;
	logic [7:0] gap;
	logic       lo_q;
	logic       en1;
	logic       en2;
	wire logic  wc = BUS_REQ.wr && BUS_REQ.addr == ADDR_TIMER_CONTROL;
	wire logic  lfell = lo_q && !LOW_OUTPUT;
	wire logic  m1 = ctl[6:4] == 3'h5 && !psc[3] && ldat != ALL_ONES;
	// Shadow of written settings and time since the last write
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			ctl <= ZERO_BYTE;
			psc <= ZERO_BYTE;
			ldat <= ZERO_BYTE;
			since <= 10'h000;
			gap <= ZERO_BYTE;
			lo_q <= 1'h1;
			en1 <= 1'h0;
			en2 <= 1'h0;
		end
		else
		begin
			since <= BUS_REQ.wr ? 10'h000 : since + {9'h000, since != 10'h3FF};
			if (wc)
				ctl <= BUS_REQ.wdata;
			if (BUS_REQ.wr && BUS_REQ.addr == ADDR_PRESCALER_CONFIG)
				psc <= BUS_REQ.wdata;
			if (BUS_REQ.wr && BUS_REQ.addr == ADDR_LOW_MATCH_DATA)
				ldat <= BUS_REQ.wdata;
			gap <= lfell ? ZERO_BYTE : gap + ONE_BYTE;
			lo_q <= LOW_OUTPUT;
			en1 <= ctl[2] | ctl[0];
			en2 <= en1;
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);
	chk_rdata_idle: assert property (!BUS_REQ.rd |=> BUS_RDATA == ZERO_BYTE)
		else $error("read data not zero");
	chk_ctl_rdback: assert property (wc ##2 BUS_REQ.rd && BUS_REQ.addr == ADDR_TIMER_CONTROL
		|=> (BUS_RDATA & 8'hF5) == ($past(BUS_REQ.wdata, 3) & 8'hF5))
		else $error("control readback differs");
	chk_irq_enable: assert property (IRQ_REQUEST |-> ctl[2] || ctl[0] || en1 || en2)
		else $error("request without enable");
	chk_low_stop: assert property (since > 10'h003 && !ctl[6] |-> LOW_OUTPUT)
		else $error("low output not high when stopped");
	chk_high_stop: assert property (since > 10'h003 && !ctl[7] |-> HIGH_OUTPUT)
		else $error("high output not high when stopped");
	chk_low_full: assert property (since > 10'h003 && ctl[6] && ldat == ALL_ONES
		|-> !LOW_OUTPUT) else $error("low output not held low");
	chk_reset_out: assert property ($fell(SYS_RST) |-> LOW_OUTPUT && HIGH_OUTPUT
		&& !IRQ_REQUEST) else $error("outputs wrong after reset");
	chk_pwm_period: assert property (lfell && m1 && since > 10'h208 |-> gap == 8'hFF)
		else $error("pwm period wrong");
	cover property (lfell && m1);
	cover property (IRQ_REQUEST);
	cover property (wc ##2 BUS_REQ.rd);
endmodule
bind dbt_timer dbt_timer_sva u_sva
(
	.CLK_SYS         (CLK_SYS),
	.SYS_RST         (SYS_RST),
	.BUS_REQ         (BUS_REQ),
	.BUS_RDATA       (BUS_RDATA),
	.EVENT_INPUT_PIN (EVENT_INPUT_PIN),
	.LOW_OUTPUT      (LOW_OUTPUT),
	.HIGH_OUTPUT     (HIGH_OUTPUT),
	.IRQ_REQUEST     (IRQ_REQUEST)
);
`default_nettype wire

// [tb/tb_dbt_timer.sv]
`default_nettype none
module tb_dbt_timer
	import dbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clk_sys;
	logic            sys_rst;
	dbt_bus_req_type req;
	logic [7:0]      rdata;
	logic            ev_pin;
	logic            low_out;
	logic            high_out;
	logic            irq;
	logic            pend;
	logic [7:0]      exp_q[$];
	logic [7:0]      r;
	int              n_errors;
	int              n_compared;
	dbt_timer dut
	(
		.CLK_SYS         (clk_sys),
		.SYS_RST         (sys_rst),
		.BUS_REQ         (req),
		.BUS_RDATA       (rdata),
		.EVENT_INPUT_PIN (ev_pin),
		.LOW_OUTPUT      (low_out),
		.HIGH_OUTPUT     (high_out),
		.IRQ_REQUEST     (irq)
	);
	always #5 clk_sys = ~clk_sys;
	task end_sim;
	begin
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task cmp(input logic [8:0] got, input logic [8:0] exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
	begin
		@(posedge clk_sys);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'h1;
		@(posedge clk_sys);
		req.wr <= 1'h0;
	end
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
	begin
		@(posedge clk_sys);
		req.addr <= a;
		req.rd <= 1'h1;
		exp_q.push_back(e);
		@(posedge clk_sys);
		req.rd <= 1'h0;
	end
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys)
	begin
		pend <= req.rd;
	end
	// Compared at the falling edge, where the registered data has settled
	always @(negedge clk_sys)
	begin
		if (pend)
			cmp({1'h0, rdata}, exp_q.pop_front());
	end
	function automatic logic pick(input logic h);
		return h ? high_out : low_out;
	endfunction
	task hold(input logic h, input logic v, output int n);
	begin
		n = 0;
		while (pick(h) === v && n < 600)
		begin
			@(negedge clk_sys);
			n++;
		end
	end
	endtask
	// Length of one whole level of an output, in clocks
	task span(input logic h, input logic v, input logic [8:0] e);
		int n;
	begin
		hold(h, v, n);
		hold(h, ~v, n);
		hold(h, v, n);
		cmp(n[8:0], e);
	end
	endtask
	initial
	begin
		#50us;
		n_errors++;
		end_sim;
	end
	initial
	begin
		clk_sys = 1'h0;
		sys_rst = 1'h1;
		req = '0;
		ev_pin = 1'h0;
		pend = 1'h0;
		n_errors = 0;
		n_compared = 0;
		void'($urandom(32'h1FF95714));
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rd(ADDR_TIMER_CONTROL, RESET_BYTE);
		rd(16'hFE1F, ZERO_BYTE);
		r = 8'($urandom());
		wr(ADDR_LOW_MATCH_DATA, r);
		rd(ADDR_LOW_MATCH_DATA, r);
		wr(ADDR_LOW_COUNTER, 8'h55);
		rd(ADDR_LOW_COUNTER, ZERO_BYTE);
		wr(ADDR_PRESCALER_CONFIG, 8'h80);
		wr(ADDR_LOW_MATCH_DATA, 8'h03);
		wr(ADDR_HIGH_MATCH_DATA, 8'h01);
		wr(ADDR_TIMER_CONTROL, 8'hC1);
		span(1'h0, 1'h1, 9'h008);
		span(1'h1, 1'h1, 9'h008);
		cmp({8'h00, irq}, 9'h001);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		// Second write clears a flag that a last tick may have set
		wr(ADDR_TIMER_CONTROL, 8'h00);
		rd(ADDR_TIMER_CONTROL, ZERO_BYTE);
		rd(ADDR_LOW_COUNTER, ZERO_BYTE);
		cmp({8'h00, irq}, 9'h000);
		cmp({8'h00, low_out}, 9'h001);
		wr(ADDR_PRESCALER_CONFIG, 8'h00);
		wr(ADDR_TIMER_CONTROL, 8'h50);
		span(1'h0, 1'h0, 9'h004);
		span(1'h0, 1'h1, 9'h0FC);
		cmp({8'h00, high_out}, 9'h001);
		repeat (600) @(negedge clk_sys);
		wr(ADDR_LOW_MATCH_DATA, ALL_ONES);
		repeat (600) @(negedge clk_sys);
		cmp({8'h00, low_out}, 9'h000);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		repeat (4) @(negedge clk_sys);
		end_sim;
	end
endmodule
`default_nettype wire
